/* File: verilog/spihc_ctrl.sv */
// Control, status and host sequencer of the serial port in I2C operation.
//
// Added by the designer: the address map and the plain strobed port.
`timescale 1ns/100ps
`include "spihc_defs.svh"
module spihc_ctrl
    import spihc_pkg::*;
(
    // Clock and reset.
    input  wire logic       clk_sys,
    input  wire logic       srst,
    // Register port.
    input  wire logic [3:0] reg_addr,
    input  wire logic [7:0] reg_wdata,
    input  wire logic       reg_wr,
    input  wire logic       reg_rd,
    output logic      [7:0] reg_rdata,
    // I2C pins, open drain.
    input  wire logic       sda_in,
    output logic            sda_out,
    output logic            sda_oe,
    input  wire logic       scl_in,
    output logic            scl_out,
    output logic            scl_oe,
    // Client stretch request from the client engine.
    input  wire logic       client_hold_req,
    // Interrupt.
    output logic            irq
);

    typedef struct packed {
        logic [7:0]   ctrl1;
        logic [7:0]   ctrl2;
        logic [7:0]   reload;
        logic [7:0]   buffer;
        logic [7:0]   shreg;
        logic         stop_flag;
        logic         start_flag;
        logic [2:0]   irq_stat;
        logic [2:0]   irq_mask;
        spihc_state_t state;
        spihc_kind_t  kind;
        logic [7:0]   brg;
        logic [3:0]   bitn;
        logic         sda_lo;
        logic         scl_lo;
        logic [7:0]   rdata;
    } spihc_regs_t;

    spihc_regs_t r_q;
    spihc_regs_t r_d;

    logic       sda_s;
    logic       scl_s;
    logic       start_ev;
    logic       stop_ev;
    logic       enabled;
    logic       host_mode;
    logic       client_mode;
    logic       idle;
    logic       brg_tc;
    logic [2:0] events;

    // True when the mode code selects an I2C client mode.
    function automatic logic is_client(input logic [3:0] m);
        return m == `SPIHC_MODE_CL7 || m == `SPIHC_MODE_CL10 ||
               m == `SPIHC_MODE_CL7SP || m == `SPIHC_MODE_CL10SP;
    endfunction : is_client

    spihc_bus_watch u_watch (
        .clk_sys    (clk_sys),
        .srst       (srst),
        .sda_in     (sda_in),
        .scl_in     (scl_in),
        .sda_s      (sda_s),
        .scl_s      (scl_s),
        .start_seen (start_ev),
        .stop_seen  (stop_ev)
    );

    // Decoded mode and idle state.
    assign enabled     = r_q.ctrl1[`SPIHC_C1_EN];
    assign host_mode   = enabled && r_q.ctrl1[3:0] == `SPIHC_MODE_HOST;
    assign client_mode = enabled && is_client(r_q.ctrl1[3:0]);
    assign idle        = r_q.state == SPIHC_IDLE;
    // The counter ends a half period when it reaches zero.
    assign brg_tc      = r_q.brg == 8'h00;

    // Host sequencer, register writes and status update.
    always_comb begin
        r_d    = r_q;
        events = 3'h0;
        r_d.brg = brg_tc ? r_q.reload : r_q.brg - 8'h01;
        // Register writes; control bits stay writable, requests need idle.
        if (reg_wr) begin
            unique case (reg_addr)
                `SPIHC_OFF_CTRL1: begin
                    r_d.ctrl1 = reg_wdata;
                end
                `SPIHC_OFF_CTRL2: begin
                    r_d.ctrl2[`SPIHC_C2_ACKDAT] = reg_wdata[5];
                    if (client_mode) begin
                        r_d.ctrl2[0] = reg_wdata[0];
                    end else if (idle && host_mode) begin
                        r_d.ctrl2[4:0] = reg_wdata[4:0];
                    end
                end
                `SPIHC_OFF_RELOAD: begin
                    r_d.reload = reg_wdata;
                end
                `SPIHC_OFF_BUFFER: begin
                    if (idle) begin
                        r_d.buffer = reg_wdata;
                    end
                end
                `SPIHC_OFF_IRQ_STAT: begin
                    r_d.irq_stat = r_q.irq_stat & ~reg_wdata[2:0];
                end
                `SPIHC_OFF_IRQ_MASK: begin
                    r_d.irq_mask = reg_wdata[2:0];
                end
                default: begin
                end
            endcase
        end
        // Launch one request from idle; priority start, restart, stop, ack.
        if (idle && host_mode) begin
            r_d.state = SPIHC_PH1;
            r_d.brg   = r_q.reload;
            if (r_q.ctrl2[`SPIHC_C2_STREQ]) begin
                r_d.kind = SPIHC_K_START;
            end else if (r_q.ctrl2[`SPIHC_C2_RSREQ]) begin
                r_d.kind = SPIHC_K_RSTRT;
            end else if (r_q.ctrl2[`SPIHC_C2_STOPREQ]) begin
                r_d.kind = SPIHC_K_STOP;
            end else if (r_q.ctrl2[`SPIHC_C2_ACKREQ]) begin
                r_d.kind = SPIHC_K_ACK;
            end else if (r_q.ctrl2[`SPIHC_C2_RXREQ]) begin
                r_d.kind = SPIHC_K_RX;
                r_d.bitn = 4'h8;
            end else if (reg_wr && reg_addr == `SPIHC_OFF_BUFFER) begin
                r_d.kind  = SPIHC_K_TX;
                r_d.bitn  = 4'h9;
                r_d.shreg = reg_wdata;
            end else begin
                r_d.state = SPIHC_IDLE;
            end
        end else if (!idle && brg_tc) begin
            // Each phase lasts one reload half period.
            unique case (r_q.state)
                SPIHC_PH1: begin
                    r_d.state = SPIHC_PH2;
                    unique case (r_q.kind)
                        SPIHC_K_START: begin
                            r_d.sda_lo = 1'b1;
                        end
                        SPIHC_K_RSTRT: begin
                            r_d.sda_lo = 1'b0;
                            r_d.scl_lo = 1'b0;
                        end
                        SPIHC_K_STOP: begin
                            r_d.sda_lo = 1'b1;
                            r_d.scl_lo = 1'b0;
                        end
                        SPIHC_K_ACK: begin
                            r_d.sda_lo = ~r_q.ctrl2[`SPIHC_C2_ACKDAT];
                            r_d.scl_lo = 1'b0;
                        end
                        default: begin
                            // Pull SCL low and set the first bit at once,
                            // so no idle high half precedes the data.
                            r_d.state  = SPIHC_BIT;
                            r_d.scl_lo = 1'b1;
                            r_d.bitn   = r_q.bitn - 4'h1;
                            r_d.sda_lo = r_q.kind == SPIHC_K_TX &&
                                         r_q.bitn != 4'h1 &&
                                         !r_q.shreg[7];
                            if (r_q.kind == SPIHC_K_TX) begin
                                r_d.shreg = {r_q.shreg[6:0], 1'b0};
                            end
                        end
                    endcase
                end
                SPIHC_PH2: begin
                    r_d.state = SPIHC_PH3;
                    unique case (r_q.kind)
                        SPIHC_K_START: r_d.scl_lo = 1'b1;
                        SPIHC_K_RSTRT: r_d.sda_lo = 1'b1;
                        SPIHC_K_STOP:  r_d.sda_lo = 1'b0;
                        default:       r_d.scl_lo = 1'b1;
                    endcase
                end
                SPIHC_PH3: begin
                    r_d.state = SPIHC_DONE;
                    if (r_q.kind == SPIHC_K_RSTRT) begin
                        r_d.scl_lo = 1'b1;
                    end
                end
                SPIHC_BIT: begin
                    // Low half drives data, high half samples it.
                    if (r_q.scl_lo) begin
                        r_d.scl_lo = 1'b0;
                    end else if (r_q.bitn == 4'h0) begin
                        r_d.state = SPIHC_DONE;
                    end else begin
                        r_d.scl_lo = 1'b1;
                        r_d.bitn   = r_q.bitn - 4'h1;
                        r_d.sda_lo = r_q.kind == SPIHC_K_TX &&
                                     r_q.bitn != 4'h1 && !r_q.shreg[7];
                        if (r_q.kind == SPIHC_K_TX) begin
                            r_d.shreg = {r_q.shreg[6:0], 1'b0};
                        end
                    end
                    if (!r_q.scl_lo && r_q.kind == SPIHC_K_RX) begin
                        r_d.shreg = {r_q.shreg[6:0], sda_s};
                    end
                end
                SPIHC_DONE: begin
                    // Sequence complete: release request and flag the event.
                    r_d.state = SPIHC_IDLE;
                    events[`SPIHC_EV_DONE] = 1'b1;
                    unique case (r_q.kind)
                        SPIHC_K_START: r_d.ctrl2[0] = 1'b0;
                        SPIHC_K_RSTRT: r_d.ctrl2[1] = 1'b0;
                        SPIHC_K_STOP:  r_d.ctrl2[2] = 1'b0;
                        SPIHC_K_ACK:   r_d.ctrl2[4] = 1'b0;
                        SPIHC_K_RX: begin
                            r_d.ctrl2[3] = 1'b0;
                            r_d.buffer   = r_q.shreg;
                        end
                        default: begin
                        end
                    endcase
                end
                default: begin
                    r_d.state = SPIHC_IDLE;
                end
            endcase
        end
        // Last bus condition seen; cleared while the port is off.
        if (stop_ev) begin
            r_d.stop_flag  = 1'b1;
            r_d.start_flag = 1'b0;
        end else if (start_ev) begin
            r_d.stop_flag  = 1'b0;
            r_d.start_flag = 1'b1;
        end
        if (!enabled) begin
            r_d.stop_flag  = 1'b0;
            r_d.start_flag = 1'b0;
        end
        // Leaving host mode drops any host drive so a client never
        // inherits a held SCL or SDA.
        if (!host_mode) begin
            r_d.state  = SPIHC_IDLE;
            r_d.sda_lo = 1'b0;
            r_d.scl_lo = 1'b0;
        end
        events[`SPIHC_EV_STOP]  = stop_ev && enabled;
        events[`SPIHC_EV_START] = start_ev && enabled;
        // Set wins over a clear in the same cycle.
        r_d.irq_stat = r_d.irq_stat | events;
        // Read data stand in the cycle after the read strobe.
        if (reg_rd) begin
            unique case (reg_addr)
                `SPIHC_OFF_STATUS:   r_d.rdata = {3'h0, r_q.stop_flag,
                                                  r_q.start_flag, 2'h0,
                                                  !idle};
                `SPIHC_OFF_CTRL1:    r_d.rdata = r_q.ctrl1;
                `SPIHC_OFF_CTRL2:    r_d.rdata = r_q.ctrl2;
                `SPIHC_OFF_RELOAD:   r_d.rdata = r_q.reload;
                `SPIHC_OFF_BUFFER:   r_d.rdata = r_q.buffer;
                `SPIHC_OFF_IRQ_STAT: r_d.rdata = {5'h0, r_q.irq_stat};
                `SPIHC_OFF_IRQ_MASK: r_d.rdata = {5'h0, r_q.irq_mask};
                default:             r_d.rdata = `SPIHC_RST_BYTE;
            endcase
        end else begin
            r_d.rdata = `SPIHC_RST_BYTE;
        end
    end

    // State register; everything resets idle with the bus released.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            r_q        <= '0;
            r_q.reload <= `SPIHC_RST_RELOAD;
            r_q.state  <= SPIHC_IDLE;
            r_q.kind   <= SPIHC_K_START;
        end else begin
            r_q <= r_d;
        end
    end

    // Open-drain pins and interrupt.
    assign sda_out   = 1'b0;
    assign sda_oe    = r_q.sda_lo;
    assign scl_out   = 1'b0;
    // Client stretches only while the stretch enable is set.
    assign scl_oe    = r_q.scl_lo || (client_mode &&
                       r_q.ctrl2[`SPIHC_C2_STREQ] && client_hold_req);
    assign reg_rdata = r_q.rdata;
    assign irq       = |(r_q.irq_stat & r_q.irq_mask);

endmodule : spihc_ctrl

/* File: verilog/spihc_defs.svh */
// Constants for the serial port I2C host control block.
//
// Functional notes
// - Reload 27h at 16 MHz gives 200 kHz; two terminal counts per SCL period.
// - Stored ack value bit is driven as the ack; 1 is NACK, 0 ACK.
// - Ack request starts an ack sequence sending the value bit, then clears.
// - Stop request generates a Stop condition and clears when it completes.
// - Restart request generates a Repeated Start, then clears automatically.
// - Host start bit generates a Start, clears itself; 0 means idle.
// - Client mode: start bit set enables SCL stretching, clear never stretches.
// - Stop-seen flag reads 1 when the last detected condition was a Stop.
// - Stop-seen flag is cleared whenever the serial port is disabled.
// - Requests are refused and buffer writes ignored unless I2C logic idle.
`ifndef SPIHC_DEFS_SVH
`define SPIHC_DEFS_SVH

// Register offsets.
`define SPIHC_OFF_STATUS   4'h0
`define SPIHC_OFF_CTRL1    4'h1
`define SPIHC_OFF_CTRL2    4'h2
`define SPIHC_OFF_RELOAD   4'h3
`define SPIHC_OFF_BUFFER   4'h4
`define SPIHC_OFF_IRQ_STAT 4'h5
`define SPIHC_OFF_IRQ_MASK 4'h6

// Field positions.
`define SPIHC_ST_STOP      4
`define SPIHC_ST_START     3
`define SPIHC_C1_EN        5
`define SPIHC_C1_HOLD      4
`define SPIHC_C2_ACKDAT    5
`define SPIHC_C2_ACKREQ    4
`define SPIHC_C2_RXREQ     3
`define SPIHC_C2_STOPREQ   2
`define SPIHC_C2_RSREQ     1
`define SPIHC_C2_STREQ     0

// Interrupt event bits.
`define SPIHC_EV_DONE      0
`define SPIHC_EV_STOP      1
`define SPIHC_EV_START     2

// Mode codes and reset values.
`define SPIHC_MODE_HOST    4'h8
`define SPIHC_MODE_CL7     4'h6
`define SPIHC_MODE_CL10    4'h7
`define SPIHC_MODE_CL7SP   4'hE
`define SPIHC_MODE_CL10SP  4'hF
`define SPIHC_RST_BYTE     8'h00
`define SPIHC_RST_RELOAD   8'h27

`endif

/* File: verilog/spihc_pkg.sv */
// Types for the serial port I2C host control block.
package spihc_pkg;

    // Host sequencer states, Gray coded in listing order rather than along the path.
    typedef enum logic [3:0] {
        SPIHC_IDLE = 4'h0,
        SPIHC_PH1  = 4'h1,
        SPIHC_PH2  = 4'h3,
        SPIHC_PH3  = 4'h2,
        SPIHC_BIT  = 4'h6,
        SPIHC_DONE = 4'h7
    } spihc_state_t;

    // Sequence kind being run.
    typedef enum logic [2:0] {
        SPIHC_K_START = 3'h0,
        SPIHC_K_RSTRT = 3'h1,
        SPIHC_K_STOP  = 3'h2,
        SPIHC_K_ACK   = 3'h3,
        SPIHC_K_RX    = 3'h4,
        SPIHC_K_TX    = 3'h5
    } spihc_kind_t;

endpackage : spihc_pkg

/* File: verilog/spihc_bus_watch.sv */
// Synchronises SDA and SCL and detects Start and Stop conditions.
`timescale 1ns/100ps
module spihc_bus_watch
    import spihc_pkg::*;
(
    // Clock and reset.
    input  wire logic clk_sys,
    input  wire logic srst,
    // Raw bus pins.
    input  wire logic sda_in,
    input  wire logic scl_in,
    // Synchronised levels and events.
    output logic      sda_s,
    output logic      scl_s,
    output logic      start_seen,
    output logic      stop_seen
);

    typedef struct packed {
        logic [1:0] sda_m;
        logic [1:0] scl_m;
        logic       sda_p;
        logic       start;
        logic       stop;
    } spihc_watch_t;

    spihc_watch_t st_q;
    spihc_watch_t st_d;

    // Two-stage synchronisers; only the second stage feeds the detector.
    always_comb begin
        st_d       = st_q;
        st_d.sda_m = {st_q.sda_m[0], sda_in};
        st_d.scl_m = {st_q.scl_m[0], scl_in};
        st_d.sda_p = st_q.sda_m[1];
        st_d.start = st_q.scl_m[1] & st_q.sda_p & ~st_q.sda_m[1];
        st_d.stop  = st_q.scl_m[1] & ~st_q.sda_p & st_q.sda_m[1];
    end

    // State register; bus lines are idle high after reset.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            st_q <= '{sda_m: 2'h3, scl_m: 2'h3, sda_p: 1'b1,
                      start: 1'b0, stop: 1'b0};
        end else begin
            st_q <= st_d;
        end
    end

    assign sda_s      = st_q.sda_m[1];
    assign scl_s      = st_q.scl_m[1];
    assign start_seen = st_q.start;
    assign stop_seen  = st_q.stop;

endmodule : spihc_bus_watch

/* File: tb/spihc_ctrl_assertions.sv */
// Port assertions for the serial port I2C control block.
`timescale 1ns/100ps
module spihc_ctrl_assertions
    import spihc_pkg::*;
(
    // Clock and reset.
    input wire logic       clk_sys,
    input wire logic       srst,
    // Register port.
    input wire logic [3:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic       reg_wr,
    input wire logic       reg_rd,
    input wire logic [7:0] reg_rdata,
    // Pins, client hold and interrupt.
    input wire logic       sda_in,
    input wire logic       sda_out,
    input wire logic       sda_oe,
    input wire logic       scl_in,
    input wire logic       scl_out,
    input wire logic       scl_oe,
    input wire logic       client_hold_req,
    input wire logic       irq
);
    logic       en_q, str_q, act_q, wr1, wr2, go, host, cli;
    logic [3:0] mode_q;
    logic [7:0] rl_q, mk_q;
    logic [8:0] cnt_q, h1, h2;
    // Decoded writes and the shadowed mode.
    assign wr1 = reg_wr && reg_addr == 4'h1;
    assign wr2 = reg_wr && reg_addr == 4'h2;
    assign host = en_q && mode_q == 4'h8;
    assign cli = en_q && mode_q[2:1] == 2'b11;
    assign go = wr2 && reg_wdata[0] && host;
    // One and two half periods of the serial clock.
    assign h1 = {1'b0, rl_q} + 9'h001;
    assign h2 = {h1[7:0], 1'b0};
    // Shadow of software settings and a cycle count since a start.
    always_ff @(posedge clk_sys) begin
        if (srst) begin
            en_q <= 1'b0;
            mode_q <= 4'h0;
            str_q <= 1'b0;
            act_q <= 1'b0;
            rl_q <= 8'h27;
            mk_q <= 8'h00;
            cnt_q <= 9'h000;
        end else begin
            if (wr1) en_q <= reg_wdata[5];
            if (wr1) mode_q <= reg_wdata[3:0];
            if (wr1 || (wr2 && cli)) str_q <= wr2 && reg_wdata[0];
            if (reg_wr && reg_addr == 4'h3) rl_q <= reg_wdata;
            if (reg_wr && reg_addr == 4'h6) mk_q <= reg_wdata;
            if (go) act_q <= 1'b1;
            else if (wr2 && cnt_q > h2 + 9'h007) act_q <= 1'b0;
            cnt_q <= go ? 9'h000 : cnt_q + {8'h00, cnt_q != 9'h1FF};
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (srst);
    AST_RST_IDLE: assert property ($fell(srst) |-> !sda_oe && !scl_oe
        && !irq && reg_rdata == 8'h00) else $error("outputs busy after reset");
    AST_OPEN_DRAIN: assert property (!sda_out && !scl_out)
        else $error("pin driven high");
    AST_START_SDA: assert property ($rose(sda_oe) && act_q |->
        cnt_q >= h1 && cnt_q <= h1 + 9'h004) else $error("start sda timing");
    AST_START_SCL: assert property ($rose(scl_oe) && act_q |->
        cnt_q >= h2 && cnt_q <= h2 + 9'h006) else $error("start scl timing");
    AST_STOP_REL: assert property (wr2 && reg_wdata[2] && host && !act_q
        |-> ##[1:400] !sda_oe && !scl_oe) else $error("stop left bus held");
    AST_ACK_LOW: assert property (wr2 && reg_wdata[5:4] == 2'b01 && host
        |-> ##[1:200] sda_oe && !scl_oe) else $error("ack not driven");
    AST_NACK_REL: assert property (wr2 && reg_wdata[5:4] == 2'b11 && host
        |-> ##[1:200] !sda_oe && !scl_oe) else $error("nack not released");
    AST_REFUSE: assert property (wr2 && !en_q |=> (!sda_oe && !scl_oe)[*8])
        else $error("request run while disabled");
    AST_STRETCH_ON: assert property ((cli && str_q && client_hold_req)[*3]
        |-> scl_oe) else $error("stretch not applied");
    AST_STRETCH_OFF: assert property ((cli && !str_q)[*3] |-> !scl_oe)
        else $error("stretch while disabled");
    AST_STOP_FLAG: assert property (reg_rd && reg_addr == 4'h0 && !en_q
        && !$past(en_q) |=> !reg_rdata[4]) else $error("stop flag kept");
    AST_IRQ_MASK: assert property ((mk_q[2:0] == 3'h0)[*3] |-> !irq)
        else $error("irq with mask clear");
    AST_RD_ZERO: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    // Main scenarios reached.
    cover property (go);
    cover property (wr2 && reg_wdata[2] && host);
    cover property (cli && str_q && client_hold_req && scl_oe);
endmodule : spihc_ctrl_assertions

/* File: tb/spihc_i2c_peer.sv */
// Behavioural model of the other devices on SDA and SCL.
`timescale 1ns/100ps
module spihc_i2c_peer (
    // Block drive enables, high pulls the line low.
    input  wire logic sda_oe,
    input  wire logic scl_oe,
    // Bench control, runs the peer clock within a frame.
    input  wire logic run,
    // Resolved bus levels.
    output logic      sda_line,
    output logic      scl_line
);
    logic scl_low;
    // Peer clock of 160 ns, unrelated in phase, still between frames.
    initial begin
        scl_low = 1'b0;
        #37;
        forever begin
            #80;
            scl_low = run ? !scl_low : 1'b0;
        end
    end
    // Pull-ups: a released line reads high and any low drive wins.
    assign sda_line = !sda_oe;
    assign scl_line = !(scl_oe || scl_low);
endmodule : spihc_i2c_peer

/* File: tb/tb_top.sv */
// Self-checking bench for the serial port I2C control block.
`timescale 1ns/100ps
module tb_top;
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wd;
        logic       w;
        logic [7:0] exp;
    } spihc_row_t;
    logic       clk_sys, sda_out, sda_oe, scl_out, scl_oe, irq;
    logic       srst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, run = 1'b0;
    logic       client_hold_req = 1'b0, sda_line, scl_line;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, reg_rdata, d;
    int         mismatches = 0, checks = 0;
    spihc_row_t rows [12];
    logic [7:0] reqs [5];
    spihc_ctrl uut (.clk_sys(clk_sys), .srst(srst), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_rdata(reg_rdata), .sda_in(sda_line), .sda_out(sda_out),
        .sda_oe(sda_oe), .scl_in(scl_line), .scl_out(scl_out),
        .scl_oe(scl_oe), .client_hold_req(client_hold_req), .irq(irq));
    spihc_i2c_peer u_peer (.sda_oe(sda_oe), .scl_oe(scl_oe), .run(run),
        .sda_line(sda_line), .scl_line(scl_line));
    // System clock of 4 ns.
    initial begin
        clk_sys = 1'b0;
        forever #2 clk_sys = !clk_sys;
    end
    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop;
        $display("checks %0d mismatches %0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    // Compares a seen value with the expected one.
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    // One-cycle register write.
    task automatic wr(input logic [3:0] a, input logic [7:0] v);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= v;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
    endtask : wr
    // One-cycle register read; data is taken in the following cycle.
    task automatic rd(input logic [3:0] a);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // Polls the control two requests until hardware has cleared them.
    task automatic poll;
        int n;
        n = 0;
        rd(4'h2);
        while (d[4:0] !== 5'h00 && n < 500) begin
            rd(4'h2);
            n++;
        end
        if (n == 500) begin
            mismatches++;
            report_and_stop();
        end
    endtask : poll
    // Main sequence: register table, host sequences, flags, client mode.
    initial begin
        int k;
        rows = '{'{4'h0, 8'h00, 1'b0, 8'h00}, '{4'h1, 8'h00, 1'b0, 8'h00},
            '{4'h2, 8'h00, 1'b0, 8'h00}, '{4'h3, 8'h00, 1'b0, 8'h27},
            '{4'h6, 8'h00, 1'b0, 8'h00}, '{4'h2, 8'h21, 1'b1, 8'h20},
            '{4'h6, 8'h05, 1'b1, 8'h05}, '{4'h6, 8'h00, 1'b1, 8'h00},
            '{4'h9, 8'h5A, 1'b1, 8'h00}, '{4'h1, 8'h28, 1'b1, 8'h28},
            '{4'h3, 8'h03, 1'b1, 8'h03}, '{4'h2, 8'h00, 1'b1, 8'h00}};
        reqs = '{8'h02, 8'h30, 8'h10, 8'h08, 8'h04};
        repeat (12) @(posedge clk_sys);
        srst <= 1'b0;
        for (int i = 0; i < 12; i++) begin
            if (rows[i].w) wr(rows[i].addr, rows[i].wd);
            rd(rows[i].addr);
            chk("register", d, rows[i].exp);
        end
        // Start with a stop written while busy; the stop must be dropped.
        wr(4'h2, 8'h01);
        wr(4'h2, 8'h04);
        poll();
        repeat (20) @(posedge clk_sys);
        rd(4'h2);
        chk("ctrl2 after start", d, 8'h00);
        chk("sda held", {7'h00, sda_line}, 8'h00);
        for (int i = 0; i < 5; i++) begin
            wr(4'h2, reqs[i]);
            poll();
            chk("ctrl2", d, reqs[i] & 8'h20);
        end
        repeat (8) @(negedge clk_sys);
        chk("sda after stop", {7'h00, sda_line}, 8'h01);
        chk("scl after stop", {7'h00, scl_line}, 8'h01);
        rd(4'h0);
        chk("stop seen", d & 8'h19, 8'h10);
        // Interrupt raised by the stop event once unmasked, then cleared.
        wr(4'h6, 8'h02);
        repeat (3) @(negedge clk_sys);
        chk("irq on", {7'h00, irq}, 8'h01);
        wr(4'h5, 8'h02);
        repeat (3) @(negedge clk_sys);
        chk("irq off", {7'h00, irq}, 8'h00);
        wr(4'h1, 8'h08);
        rd(4'h0);
        chk("stop flag off", d & 8'h10, 8'h00);
        wr(4'h1, 8'h28);
        wr(4'h2, 8'h01);
        poll();
        repeat (8) @(posedge clk_sys);
        rd(4'h0);
        chk("start seen", d & 8'h18, 8'h08);
        // Client mode: stretch holds the peer clock low until disabled.
        wr(4'h1, 8'h26);
        wr(4'h2, 8'h01);
        client_hold_req <= 1'b1;
        run <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            repeat (25) @(negedge clk_sys);
            chk("scl stretched", {7'h00, scl_line}, 8'h00);
        end
        wr(4'h2, 8'h00);
        k = 0;
        while (scl_line !== 1'b1 && k < 200) begin
            @(negedge clk_sys);
            k++;
        end
        chk("scl released", {7'h00, scl_line}, 8'h01);
        run <= 1'b0;
        client_hold_req <= 1'b0;
        // Second reset in mid-run.
        srst <= 1'b1;
        repeat (3) @(posedge clk_sys);
        srst <= 1'b0;
        rd(4'h1);
        chk("ctrl1 after reset", d, 8'h00);
        report_and_stop();
    end
endmodule : tb_top
bind spihc_ctrl spihc_ctrl_assertions u_chk (.clk_sys(clk_sys), .srst(srst),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .sda_in(sda_in),
    .sda_out(sda_out), .sda_oe(sda_oe), .scl_in(scl_in), .scl_out(scl_out),
    .scl_oe(scl_oe), .client_hold_req(client_hold_req), .irq(irq));
